// File: rtl/kbc_fast_gate.sv
// keyboard controller host status and fast gate/reset port
`timescale 1ns/100ps
module kbc_fast_gate
  import kbc_fast_pkg::*;
#(
  parameter int delay_cycles = pulse_delay_cycles,
  parameter int width_cycles = pulse_width_cycles
)(
  // clock and system reset pin
  input wire logic clk_sys,
  input wire logic rst,
  // host i/o bus, same clock
  input wire host_req_t host,
  output logic [7:0] fast_port_rdata,
  output logic fast_port_rd_valid,
  // controller side
  input wire ctrl_req_t ctrl,
  input wire logic [7:0] ctrl_port2,
  input wire logic ctrl_reset_n,
  input wire logic [7:0] fast_port_config,
  input wire logic kbd_reset_invert,
  output logic [7:0] status,
  output logic input_full_irq_n,
  // system outputs
  output logic fast_gate_line,
  output logic fast_cpu_reset_n,
  output logic cpu_addr_mask_n,
  output logic kbd_reset_out,
  // keyboard and mouse pins, open drain
  input wire logic [3:0] kbd_pins_in,
  output logic [3:0] kbd_pins_out,
  output logic [3:0] kbd_pins_oe
);
  wire logic port_enable;
  wire logic port_write;
  wire logic port_read;
  wire logic host_in_write;
  wire logic host_out_read;
  wire logic ctrl_gate_line;
  wire logic fast_reset_n;
  wire logic combined_reset_n;
  logic [1:0] port_bits;

  assign port_enable = fast_port_config[cfg_enable_bit];
  assign port_write = host.wr && host.addr == fast_port_addr
    && port_enable;
  assign port_read = host.rd && host.addr == fast_port_addr
    && port_enable;
  // data port at 60h and command port at 64h; sa2 picks which
  assign host_in_write = host.wr && (host.addr == 8'h60 || host.addr == 8'h64);
  assign host_out_read = host.rd && host.addr == 8'h60;

  status_flags u_status (
    .clk_sys(clk_sys),
    .rst(rst),
    .host_in_write(host_in_write),
    .host_sa2(host.sa2),
    .host_out_read(host_out_read),
    .ctrl(ctrl),
    .status(status)
  );
  // active low toward the controller cpu
  assign input_full_irq_n = ~status[status_ibf_bit];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) port_bits <= fast_port_reset[1:0];
    else if (port_write) port_bits <= host.wdata[1:0];
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fast_port_rdata <= fast_port_reset;
      fast_port_rd_valid <= 1'b0;
    end else begin
      fast_port_rd_valid <= port_read;
      fast_port_rdata <= fast_port_fixed | {6'h00, port_bits};
    end
  end

  pulse_timer #(
    .delay_cycles(delay_cycles),
    .width_cycles(width_cycles)
  ) u_pulse (
    .clk_sys(clk_sys),
    .rst(rst),
    .trigger(port_bits[port_rst_bit]),
    .rearm(!port_bits[port_rst_bit]),
    .pulse_n(fast_reset_n)
  );

  assign fast_gate_line = port_bits[port_gate_bit];
  assign fast_cpu_reset_n = fast_reset_n;
  assign ctrl_gate_line = ctrl_port2[ctrl_gate_port_pos];
  assign cpu_addr_mask_n = ctrl_gate_line | fast_gate_line;
  // a disabled port cannot hold kbd_reset_out in reset; fast_cpu_reset_n is not masked
  assign combined_reset_n = ctrl_reset_n
    & (fast_reset_n | ~port_enable);
  assign kbd_reset_out = combined_reset_n ^ kbd_reset_invert;
  // pins released to inputs; the serial engine lives elsewhere
  assign kbd_pins_out = 4'h0;
  assign kbd_pins_oe = 4'h0;

  a_status_reset: assert property (@(posedge clk_sys)
    $fell(rst) |-> status == status_reset)
    else $error("status not zero after reset");
  a_port_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    host.wr && host.addr == fast_port_addr && !port_enable
    |=> $stable(port_bits))
    else $error("disabled fast port accepted a write");
  a_mask_or: assert property (@(posedge clk_sys) disable iff (rst)
    cpu_addr_mask_n == (ctrl_port2[ctrl_gate_port_pos] | port_bits[1]))
    else $error("address mask not the OR of gates");
  a_port_read: assert property (@(posedge clk_sys) disable iff (rst)
    port_read |=> fast_port_rd_valid
    && fast_port_rdata[7:2] == fast_port_fixed[7:2])
    else $error("fast port fixed bits wrong");
  a_gate_write: assert property (@(posedge clk_sys) disable iff (rst)
    port_write |=> fast_gate_line == $past(host.wdata[1]))
    else $error("fast gate line did not follow write");
endmodule : kbc_fast_gate

// File: rtl/kbc_fast_pkg.sv
// package: register map, field positions, reset values and timing counts
// Functional notes
// - status bits 7:4 and 2 are controller-written
// - status byte resets to zero
// - host reads status, controller reads and writes
// - host input write captures SA2 into bit 3
// - host input write sets input-full, raises interrupt
// - controller input read clears input-full and interrupt
// - controller output write sets output-full, host read clears
// - system reset pin resets; keyboard lines become inputs
// - fast port answers only when enable bit set
// - fast port reads fixed bits, default 24h
// - bit 1 drives the fast gate line
// - address mask is OR of both gates
// - bit 0 gives low pulse, 6us after 14us
// - longer figures used, they cover both
// - new pulse only after bit 0 returns zero
// - reset clears bit 0, reset output high
// - reset drives fast gate line low
// - fast pulse ANDed with controller reset, polarity set
// - controller gate is port 2 bit 1
package kbc_fast_pkg;
  localparam logic [7:0] fast_port_addr = 8'h92;
  localparam logic [7:0] fast_port_reset = 8'h24;
  localparam logic [7:0] fast_port_fixed = 8'h24;
  localparam logic [7:0] status_reset = 8'h00;
  localparam logic [7:0] status_user_mask = 8'hf4;
  localparam int status_cmd_bit = 3;
  localparam int status_ibf_bit = 1;
  localparam int status_obf_bit = 0;
  localparam int port_gate_bit = 1;
  localparam int port_rst_bit = 0;
  localparam int cfg_enable_bit = 2;
  localparam int ctrl_gate_port_pos = 1;
  localparam int clk_mhz = 200;
  localparam int pulse_delay_ns = 14000;
  localparam int pulse_width_ns = 6000;
  localparam int pulse_delay_cycles = (pulse_delay_ns * clk_mhz + 999) / 1000;
  localparam int pulse_width_cycles = (pulse_width_ns * clk_mhz + 999) / 1000;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic sa2;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic in_read;
    logic out_write;
    logic status_write;
    logic [7:0] status_wdata;
  } ctrl_req_t;
endpackage : kbc_fast_pkg

// File: rtl/status_flags.sv
// host mailbox status byte with its hardware-set flags
`timescale 1ns/100ps
module status_flags
  import kbc_fast_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // events
  input wire logic host_in_write,
  input wire logic host_sa2,
  input wire logic host_out_read,
  input wire ctrl_req_t ctrl,
  // state
  output logic [7:0] status
);
  wire logic [7:0] ctrl_view;
  wire logic [7:0] next_status;
  // controller writes user bits and may rewrite flags; hardware events win
  assign ctrl_view = ctrl.status_write ? ctrl.status_wdata : status;
  assign next_status = {ctrl_view[7:4],
    host_in_write ? host_sa2 : ctrl_view[status_cmd_bit],
    ctrl_view[2],
    host_in_write | (ctrl_view[status_ibf_bit] & ~ctrl.in_read),
    ctrl.out_write | (ctrl_view[status_obf_bit] & ~host_out_read)};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) status <= status_reset;
    else status <= next_status;
  end

  a_ibf_set: assert property (@(posedge clk_sys) disable iff (rst)
    host_in_write |=> status[status_ibf_bit])
    else $error("input-full not set after host write");
  a_cd_capture: assert property (@(posedge clk_sys) disable iff (rst)
    host_in_write |=> status[status_cmd_bit] == $past(host_sa2))
    else $error("command flag did not follow sa2");
  a_ibf_clear: assert property (@(posedge clk_sys) disable iff (rst)
    ctrl.in_read && !host_in_write |=> !status[status_ibf_bit])
    else $error("input-full not cleared by controller read");
  a_obf_flow: assert property (@(posedge clk_sys) disable iff (rst)
    host_out_read && !ctrl.out_write |=> !status[status_obf_bit])
    else $error("output-full not cleared by host read");
endmodule : status_flags

// File: rtl/pulse_timer.sv
// delayed low pulse generator for the fast cpu reset
`timescale 1ns/100ps
module pulse_timer
  import kbc_fast_pkg::*;
#(
  parameter int delay_cycles = pulse_delay_cycles,
  parameter int width_cycles = pulse_width_cycles
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic trigger,
  input wire logic rearm,
  // output
  output logic pulse_n
);
  typedef enum logic [2:0] {
    st_idle = 3'b001, st_wait = 3'b010, st_low = 3'b100
  } pulse_state_t;
  pulse_state_t state;
  logic [15:0] count;
  logic armed;

  initial begin
    if (delay_cycles < 1 || delay_cycles > 65535 ||
        width_cycles < 1 || width_cycles > 65535)
      $error("pulse_timer counts out of range");
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= st_idle;
      count <= 16'h0000;
      armed <= 1'b1;
      pulse_n <= 1'b1;
    end else begin
      if (rearm) armed <= 1'b1;
      unique case (state)
        st_idle: if (trigger && armed) begin
          state <= st_wait;
          armed <= 1'b0;
          count <= 16'(delay_cycles - 1);
        end
        st_wait: if (count == 16'h0000) begin
          state <= st_low;
          pulse_n <= 1'b0;
          count <= 16'(width_cycles - 1);
        end else count <= count - 16'h0001;
        st_low: if (count == 16'h0000) begin
          state <= st_idle;
          pulse_n <= 1'b1;
        end else count <= count - 16'h0001;
      endcase
    end
  end

  a_pulse_delay: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(state == st_wait) |-> pulse_n [*2])
    else $error("reset pulse started too early");
  a_pulse_rearm: assert property (@(posedge clk_sys) disable iff (rst)
    state == st_idle && !armed && !rearm |=> state == st_idle)
    else $error("second pulse without rearm");
endmodule : pulse_timer

// File: verif/host_model.sv
// isa host processor model issuing one-cycle i/o reads and writes
`timescale 1ns/100ps
module host_model
  import kbc_fast_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // host bus toward the device
  output host_req_t host
);
  initial host = '0;
  // a released bus shows the inverse, so a stale value never passes
  task automatic io(input logic rd, input logic [7:0] a, input logic s,
                    input logic [7:0] d);
    @(posedge clk_sys) #1;
    host = '{rd: rd, wr: !rd, addr: a, sa2: s, wdata: d};
    @(posedge clk_sys) #1;
    host = '{rd: 1'b0, wr: 1'b0, addr: ~a, sa2: ~s, wdata: ~d};
  endtask : io
endmodule : host_model

// File: verif/tb_top.sv
// self-checking bench for the mailbox status and fast gate/reset port
`timescale 1ns/100ps
module tb_top;
  import kbc_fast_pkg::*;
  localparam int dly = 4;
  localparam int wid = 3;
  logic clk_sys = 0;
  logic rst = 1;
  host_req_t host;
  ctrl_req_t ctrl = '0;
  logic [7:0] port2 = '0, cfg = '0, rdata, status;
  logic inv = 0, crst_n = 1, rd_valid, irq_n, gate, frst_n, mask_n, kout;
  logic [3:0] pins_out, pins_oe;
  int n_fail = 0, checked = 0;
  always #2.5 clk_sys = ~clk_sys;
  host_model h (.clk_sys(clk_sys), .host(host));
  kbc_fast_gate #(.delay_cycles(dly), .width_cycles(wid)) dut (
    .clk_sys(clk_sys), .rst(rst), .host(host), .fast_port_rdata(rdata),
    .fast_port_rd_valid(rd_valid), .ctrl(ctrl), .ctrl_port2(port2),
    .ctrl_reset_n(crst_n), .fast_port_config(cfg),
    .kbd_reset_invert(inv), .status(status), .input_full_irq_n(irq_n),
    .fast_gate_line(gate), .fast_cpu_reset_n(frst_n),
    .cpu_addr_mask_n(mask_n), .kbd_reset_out(kout), .kbd_pins_in(4'h0),
    .kbd_pins_out(pins_out), .kbd_pins_oe(pins_oe));
  task automatic chk(input logic [7:0] seen, exp, input string m);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask : chk
  task automatic ctl(input ctrl_req_t c);
    @(posedge clk_sys) #1 ctrl = c;
    @(posedge clk_sys) #1 ctrl = '0;
  endtask : ctl
  task automatic t_reset;
    chk(status, 8'h00, "status reset");
    chk(rdata, 8'h24, "port reset");
    chk(gate, 1'b0, "gate reset");
    chk(frst_n, 1'b1, "reset out idle");
    chk(pins_oe, 4'h0, "pins input");
    chk(pins_out, 4'h0, "pins released");
    $display("test reset done");
  endtask : t_reset
  task automatic t_status;
    ctl('{1'b0, 1'b0, 1'b1, 8'hf4});
    chk(status, 8'hf4, "user bits");
    h.io(0, 8'h64, 1, 8'h5a);
    chk(status, 8'hfe, "command write");
    chk(irq_n, 1'b0, "irq raised");
    ctl('{1'b1, 1'b0, 1'b0, 8'h00});
    chk(status, 8'hfc, "input read");
    chk(irq_n, 1'b1, "irq cleared");
    h.io(0, 8'h60, 0, 8'h11);
    chk(status, 8'hf6, "data write");
    ctl('{1'b1, 1'b1, 1'b0, 8'h00});
    chk(status, 8'hf5, "output write");
    h.io(1, 8'h60, 0, 8'h00);
    chk(status, 8'hf4, "output read");
    $display("test status done");
  endtask : t_status
  task automatic t_port;
    h.io(0, 8'h92, 0, 8'h03);
    chk(gate, 1'b0, "disabled write");
    h.io(1, 8'h92, 0, 8'h00);
    chk(rd_valid, 1'b0, "disabled read");
    repeat (dly + wid + 2) @(posedge clk_sys);
    chk(frst_n, 1'b1, "disabled pulse");
    #1 cfg = 8'h04;
    for (int i = 0; i < 4; i++) begin
      port2 = {6'h0, i[0], 1'b0};
      h.io(0, 8'h92, 0, {6'h0, i[1], 1'b0});
      chk(gate, i[1], "gate bit");
      chk(mask_n, i[0] | i[1], "mask or");
      h.io(1, 8'h92, 0, 8'h00);
      chk(rd_valid, 1'b1, "read valid");
      chk(rdata, {6'h09, i[1], 1'b0}, "read fixed");
    end
    $display("test port done");
  endtask : t_port
  // waits for the low pulse and measures delay and width in cycles
  task automatic pulse(input logic want);
    int n, m;
    n = 0;
    m = 0;
    h.io(0, 8'h92, 0, 8'h01);
    while (frst_n && n < 40) begin
      @(posedge clk_sys) #1;
      n++;
    end
    chk(n < 40, want, "pulse seen");
    if (n < 40) begin
      chk(n >= dly, 1'b1, "pulse delay");
      chk(kout, 1'b0, "kbd reset and");
      while (!frst_n && m < 40) begin
        @(posedge clk_sys) #1;
        m++;
      end
      chk(m >= wid && m < 40, 1'b1, "pulse width");
    end
  endtask : pulse
  task automatic t_pulse;
    pulse(1);
    pulse(0);
    h.io(0, 8'h92, 0, 8'h00);
    pulse(1);
    inv = 1;
    #1 chk(kout, 1'b0, "polarity");
    inv = 0;
    crst_n = 0;
    #1 chk(kout, 1'b0, "ctrl reset");
    crst_n = 1;
    $display("test pulse done");
  endtask : t_pulse
  task automatic t_rereset;
    h.io(0, 8'h92, 0, 8'h00);
    h.io(0, 8'h92, 0, 8'h03);
    rst = 1;
    // 300 cycles of 5 ns cover 24 periods of a 16 MHz clock
    repeat (300) @(posedge clk_sys);
    #1 rst = 0;
    t_reset;
    repeat (dly + wid + 2) @(posedge clk_sys);
    chk(frst_n, 1'b1, "pulse cancelled");
    $display("test mid reset done");
  endtask : t_rereset
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  initial begin
    repeat (10) @(posedge clk_sys);
    #1 rst = 0;
    t_reset;
    t_status;
    t_port;
    t_pulse;
    t_rereset;
    final_report;
  end
  initial begin
    #20000;
    n_fail++;
    final_report;
  end
endmodule : tb_top
